//--- verilog/lsm_link_status_monitor.sv
// Purpose: real-time transmit and receive link status with AHB-Lite registers
// Assumes: raw status inputs come from core logic on mclk
// Notes: all status outputs are registered on mclk, except the unused flags tied to zero
`timescale 1ns/1ns
`default_nettype none
module lsm_link_status_monitor (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // raw core status
    input wire lsm_pkg::lsm_tx_raw_t tx_raw,
    input wire lsm_pkg::lsm_rx_raw_t rx_raw,
    // status to the application
    output lsm_pkg::lsm_tx_stat_t tx_stat,
    output lsm_pkg::lsm_rx_stat_t rx_stat,
    // interrupt
    output logic irq
);

    localparam int NL = lsm_pkg::NUM_LANES;
    localparam int TAW = lsm_pkg::TXB_AW;
    localparam int RAW = lsm_pkg::RXF_AW;

    // registered status
    logic tx_aligned;
    logic tx_ovf;
    logic tx_unf;
    logic rx_aligned;
    logic [NL-1:0] frame_locked;
    logic [NL-1:0] word_locked;
    logic reasm_ovf;
    logic [RAW-1:0] fill_level;
    logic sop_inc;
    logic eop_inc;
    logic link_err;
    logic [NL-1:0] lane_err;

    // software state
    logic [31:0] ctrl;
    logic [lsm_pkg::IRQ_W-1:0] irq_stat;
    logic [lsm_pkg::IRQ_W-1:0] irq_mask;
    logic [31:0] sop_cnt;
    logic [31:0] eop_cnt;
    logic [31:0] crc_cnt;

    // buffer occupancy from pointers
    logic [TAW:0] tx_diff;
    logic [RAW:0] rf_diff;
    logic tx_full;
    logic tx_empty;
    logic rf_full;
    assign tx_diff = tx_raw.wr_ptr - tx_raw.rd_ptr;
    assign rf_diff = rx_raw.rf_wr_ptr - rx_raw.rf_rd_ptr;
    assign tx_full = tx_diff[TAW];
    assign tx_empty = (tx_diff == '0);
    assign rf_full = rf_diff[RAW];

    // transmit status
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            tx_aligned <= 1'b0;
        end else begin
            tx_aligned <= (&tx_raw.lane_aligned) & tx_raw.ready;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            tx_ovf <= 1'b0;
        end else if (tx_raw.push && tx_full) begin
            tx_ovf <= 1'b1;
        end else if (!tx_full) begin
            tx_ovf <= 1'b0;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            tx_unf <= 1'b0;
        end else begin
            tx_unf <= tx_empty & (tx_raw.pop | tx_unf);
        end
    end

    // receive levels
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rx_aligned <= 1'b0;
            frame_locked <= '0;
            word_locked <= '0;
        end else begin
            rx_aligned <= (&rx_raw.lane_aligned) & rx_raw.ready;
            frame_locked <= rx_raw.frame_lock;
            word_locked <= rx_raw.word_lock;
        end
    end

    // reassembly fifo monitor
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            reasm_ovf <= 1'b0;
        end else if (rx_raw.rf_push && rf_full) begin
            reasm_ovf <= 1'b1;
        end else if (!rf_full) begin
            reasm_ovf <= 1'b0;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            fill_level <= '0;
        end else begin
            fill_level <= rf_diff[RAW-1:0];
        end
    end

    // packet event pulses
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            sop_inc <= 1'b0;
            eop_inc <= 1'b0;
        end else begin
            sop_inc <= rx_raw.sop_out;
            eop_inc <= rx_raw.eop_out;
        end
    end

    // check error pulses, shaped per variant
    lsm_pulse_shaper u_link_err (
        .mclk(mclk),
        .rst(rst),
        .single_mode(ctrl[lsm_pkg::CTRL_SINGLE_PULSE]),
        .ev(rx_raw.ctl_check_fail | rx_raw.data_check_fail),
        .pulse(link_err)
    );

    genvar gi;
    generate
        for (gi = 0; gi < NL; gi++) begin : g_lane
            lsm_pulse_shaper u_lane_err (
                .mclk(mclk),
                .rst(rst),
                .single_mode(ctrl[lsm_pkg::CTRL_SINGLE_PULSE]),
                .ev(rx_raw.lane_diag_fail[gi]),
                .pulse(lane_err[gi])
            );
        end
    endgenerate

    // status outputs; unused flags held at zero
    assign tx_stat = '{aligned: tx_aligned, overflow: tx_ovf, underflow: tx_unf};
    assign rx_stat = '{
        aligned: rx_aligned,
        frame_locked: frame_locked,
        word_locked: word_locked,
        link_check_error: link_err,
        lane_diag_check_error: lane_err,
        rx_overflow: 1'b0,
        rate_dec_overflow: 1'b0,
        reassembly_overrun_flag: reasm_ovf,
        fill_level: fill_level,
        sop_cntr_inc: sop_inc,
        eop_cntr_inc: eop_inc,
        idle_cntr_inc: 1'b0
    };

    // event detection for interrupts
    logic tx_aligned_d;
    logic rx_aligned_d;
    logic [NL-1:0] frame_locked_d;
    logic tx_ovf_d;
    logic tx_unf_d;
    logic reasm_ovf_d;
    logic [lsm_pkg::IRQ_W-1:0] events;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            tx_aligned_d <= 1'b0;
            rx_aligned_d <= 1'b0;
            frame_locked_d <= '0;
            tx_ovf_d <= 1'b0;
            tx_unf_d <= 1'b0;
            reasm_ovf_d <= 1'b0;
        end else begin
            tx_aligned_d <= tx_aligned;
            rx_aligned_d <= rx_aligned;
            frame_locked_d <= frame_locked;
            tx_ovf_d <= tx_ovf;
            tx_unf_d <= tx_unf;
            reasm_ovf_d <= reasm_ovf;
        end
    end

    always_comb begin
        events = '0;
        events[lsm_pkg::IRQ_TX_OVF] = tx_ovf & ~tx_ovf_d;
        events[lsm_pkg::IRQ_TX_UNF] = tx_unf & ~tx_unf_d;
        events[lsm_pkg::IRQ_TX_ALIGN_LOSS] = tx_aligned_d & ~tx_aligned;
        events[lsm_pkg::IRQ_RX_ALIGN_LOSS] = rx_aligned_d & ~rx_aligned;
        events[lsm_pkg::IRQ_LINK_CHECK] = rx_raw.ctl_check_fail | rx_raw.data_check_fail;
        events[lsm_pkg::IRQ_LANE_DIAG] = |rx_raw.lane_diag_fail;
        events[lsm_pkg::IRQ_REASM_OVF] = reasm_ovf & ~reasm_ovf_d;
        events[lsm_pkg::IRQ_FRAME_LOSS] = |(frame_locked_d & ~frame_locked);
    end

    // ahb-lite address phase capture
    logic acc;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic rd_stat;
    assign acc = hsel & htrans[1] & hready;
    assign rd_stat = acc & ~hwrite & (haddr[7:0] == lsm_pkg::OFS_IRQ_STAT);

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
        end else if (hready) begin
            wr_pend <= acc & hwrite;
            wr_addr <= haddr[7:0];
        end
    end

    // writable registers
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ctrl <= lsm_pkg::CTRL_RESET;
            irq_mask <= lsm_pkg::IRQ_MASK_RESET;
        end else if (wr_pend) begin
            if (wr_addr == lsm_pkg::OFS_CTRL) begin
                ctrl <= {31'h0000_0000, hwdata[lsm_pkg::CTRL_SINGLE_PULSE]};
            end
            if (wr_addr == lsm_pkg::OFS_IRQ_MASK) begin
                irq_mask <= hwdata[lsm_pkg::IRQ_W-1:0];
            end
        end
    end

    // sticky interrupt status, cleared by read, set wins
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            irq_stat <= '0;
        end else begin
            irq_stat <= (rd_stat ? '0 : irq_stat) | events;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(((rd_stat ? '0 : irq_stat) | events) & irq_mask);
        end
    end

    // event counters
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            sop_cnt <= 32'h0000_0000;
            eop_cnt <= 32'h0000_0000;
            crc_cnt <= 32'h0000_0000;
        end else begin
            if (sop_inc) begin
                sop_cnt <= sop_cnt + 32'h0000_0001;
            end
            if (eop_inc) begin
                eop_cnt <= eop_cnt + 32'h0000_0001;
            end
            if (events[lsm_pkg::IRQ_LINK_CHECK]) begin
                crc_cnt <= crc_cnt + 32'h0000_0001;
            end
        end
    end

    // read mux, sampled at the address phase
    logic [31:0] next_rdata;
    logic [31:0] status_word;

    always_comb begin
        status_word = 32'h0000_0000;
        status_word[lsm_pkg::ST_TX_ALIGNED] = tx_aligned;
        status_word[lsm_pkg::ST_TX_OVF] = tx_ovf;
        status_word[lsm_pkg::ST_TX_UNF] = tx_unf;
        status_word[lsm_pkg::ST_RX_ALIGNED] = rx_aligned;
        status_word[lsm_pkg::ST_REASM_OVF] = reasm_ovf;
        status_word[lsm_pkg::ST_FRAME_LOCK +: NL] = frame_locked;
        status_word[lsm_pkg::ST_WORD_LOCK +: NL] = word_locked;
    end

    always_comb begin
        next_rdata = 32'h0000_0000;
        unique case (haddr[7:0])
            lsm_pkg::OFS_CTRL: next_rdata = ctrl;
            lsm_pkg::OFS_STATUS: next_rdata = status_word;
            lsm_pkg::OFS_IRQ_STAT: next_rdata = {24'h00_0000, irq_stat};
            lsm_pkg::OFS_IRQ_MASK: next_rdata = {24'h00_0000, irq_mask};
            lsm_pkg::OFS_SOP_CNT: next_rdata = sop_cnt;
            lsm_pkg::OFS_EOP_CNT: next_rdata = eop_cnt;
            lsm_pkg::OFS_CRC_CNT: next_rdata = crc_cnt;
            lsm_pkg::OFS_FILL: next_rdata = {20'h0_0000, fill_level};
            default: next_rdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            hrdata <= 32'h0000_0000;
        end else if (acc && !hwrite) begin
            hrdata <= next_rdata;
        end
    end

    // zero wait state, always okay
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

endmodule : lsm_link_status_monitor
`default_nettype wire

//--- verilog/lsm_pkg.sv
// Purpose: shared constants and carriers for the link status monitor
// Assumes: single clock mclk, AHB-Lite register access
// Notes: lane count and buffer widths fixed
package lsm_pkg;

    // geometry
    localparam int NUM_LANES = 4;
    localparam int TXB_AW = 6;
    localparam int RXF_AW = 12;

    // stretched error pulse length in mclk cycles
    localparam logic [3:0] CRC_STRETCH_CYC = 4'h4;

    // register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h08;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h0c;
    localparam logic [7:0] OFS_SOP_CNT = 8'h10;
    localparam logic [7:0] OFS_EOP_CNT = 8'h14;
    localparam logic [7:0] OFS_CRC_CNT = 8'h18;
    localparam logic [7:0] OFS_FILL = 8'h1c;

    // reset values
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [7:0] IRQ_MASK_RESET = 8'h00;

    // ctrl fields
    localparam int CTRL_SINGLE_PULSE = 0;

    // status fields
    localparam int ST_TX_ALIGNED = 0;
    localparam int ST_TX_OVF = 1;
    localparam int ST_TX_UNF = 2;
    localparam int ST_RX_ALIGNED = 3;
    localparam int ST_REASM_OVF = 4;
    localparam int ST_FRAME_LOCK = 8;
    localparam int ST_WORD_LOCK = 12;

    // interrupt status / mask fields
    localparam int IRQ_W = 8;
    localparam int IRQ_TX_OVF = 0;
    localparam int IRQ_TX_UNF = 1;
    localparam int IRQ_TX_ALIGN_LOSS = 2;
    localparam int IRQ_RX_ALIGN_LOSS = 3;
    localparam int IRQ_LINK_CHECK = 4;
    localparam int IRQ_LANE_DIAG = 5;
    localparam int IRQ_REASM_OVF = 6;
    localparam int IRQ_FRAME_LOSS = 7;

    typedef struct packed {
        logic [NUM_LANES-1:0] lane_aligned;
        logic ready;
        logic [TXB_AW:0] wr_ptr;
        logic [TXB_AW:0] rd_ptr;
        logic push;
        logic pop;
    } lsm_tx_raw_t;

    typedef struct packed {
        logic [NUM_LANES-1:0] lane_aligned;
        logic ready;
        logic [NUM_LANES-1:0] frame_lock;
        logic [NUM_LANES-1:0] word_lock;
        logic ctl_check_fail;
        logic data_check_fail;
        logic [NUM_LANES-1:0] lane_diag_fail;
        logic [RXF_AW:0] rf_wr_ptr;
        logic [RXF_AW:0] rf_rd_ptr;
        logic rf_push;
        logic sop_out;
        logic eop_out;
    } lsm_rx_raw_t;

    typedef struct packed {
        logic aligned;
        logic overflow;
        logic underflow;
    } lsm_tx_stat_t;

    typedef struct packed {
        logic aligned;
        logic [NUM_LANES-1:0] frame_locked;
        logic [NUM_LANES-1:0] word_locked;
        logic link_check_error;
        logic [NUM_LANES-1:0] lane_diag_check_error;
        logic rx_overflow;
        logic rate_dec_overflow;
        logic reassembly_overrun_flag;
        logic [RXF_AW-1:0] fill_level;
        logic sop_cntr_inc;
        logic eop_cntr_inc;
        logic idle_cntr_inc;
    } lsm_rx_stat_t;

endpackage : lsm_pkg

//--- verilog/lsm_pulse_shaper.sv
// Purpose: turns a one-cycle error event into a single or stretched pulse
// Assumes: ev is synchronous to mclk
// Notes: pulse comes from a flip-flop
`timescale 1ns/1ns
`default_nettype none
module lsm_pulse_shaper (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // control
    input wire logic single_mode,
    input wire logic ev,
    // result
    output logic pulse
);

    logic [3:0] cnt;
    logic [3:0] next_cnt;

    always_comb begin
        if (ev) begin
            next_cnt = single_mode ? 4'h1 : lsm_pkg::CRC_STRETCH_CYC;
        end else if (cnt != 4'h0) begin
            next_cnt = cnt - 4'h1;
        end else begin
            next_cnt = 4'h0;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cnt <= 4'h0;
            pulse <= 1'b0;
        end else begin
            cnt <= next_cnt;
            pulse <= (next_cnt != 4'h0);
        end
    end

endmodule : lsm_pulse_shaper
`default_nettype wire

//--- tb/lsm_monitor_asserts.sv
// Purpose: port checks for the link status monitor
// Assumes: one-cycle status latency on mclk
// Notes: attached to the top module by bind
`timescale 1ns/1ns
`default_nettype none
module lsm_monitor_asserts (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // raw inputs and status outputs
    input wire lsm_pkg::lsm_tx_raw_t tx_raw,
    input wire lsm_pkg::lsm_rx_raw_t rx_raw,
    input wire lsm_pkg::lsm_tx_stat_t tx_stat,
    input wire lsm_pkg::lsm_rx_stat_t rx_stat
);
    default clocking @(posedge mclk);
    endclocking
    default disable iff (rst);
    // derived conditions
    wire logic tx_all = &tx_raw.lane_aligned & tx_raw.ready;
    wire logic rx_all = &rx_raw.lane_aligned & rx_raw.ready;
    wire logic [7:0] locks = {rx_raw.frame_lock, rx_raw.word_lock};
    wire logic [1:0] pkt = {rx_raw.sop_out, rx_raw.eop_out};
    wire logic [6:0] tx_diff = tx_raw.wr_ptr - tx_raw.rd_ptr;
    wire logic tx_full = tx_diff[6];
    wire logic [12:0] rf_diff = rx_raw.rf_wr_ptr - rx_raw.rf_rd_ptr;
    wire logic [11:0] fill = rf_diff[11:0];
    wire logic [3:0] diag = rx_raw.lane_diag_fail;

    chk_tx_align_all: assert property (1'b1 |=> tx_stat.aligned == $past(tx_all))
        else $error("tx aligned wrong");
    chk_rx_align_all: assert property (1'b1 |=> rx_stat.aligned == $past(rx_all))
        else $error("rx aligned wrong");
    chk_lock_levels: assert property (
        1'b1 |=> {rx_stat.frame_locked, rx_stat.word_locked} == $past(locks))
        else $error("lock levels wrong");
    chk_tx_ovf_rise: assert property (tx_raw.push && tx_full |=> tx_stat.overflow)
        else $error("tx overflow late");
    chk_tx_ovf_hold: assert property (
        tx_stat.overflow |=> tx_stat.overflow == $past(tx_full))
        else $error("tx overflow hold wrong");
    chk_tx_unf_set: assert property (
        tx_raw.pop && tx_diff == 7'h00 |=> tx_stat.underflow)
        else $error("tx underflow missing");
    chk_link_err: assert property (
        rx_raw.ctl_check_fail || rx_raw.data_check_fail |=> rx_stat.link_check_error)
        else $error("link check error missing");
    chk_lane_diag: assert property (
        |diag |=> (rx_stat.lane_diag_check_error & $past(diag)) == $past(diag))
        else $error("lane diag error missing");
    chk_unused_zero: assert property (
        !(rx_stat.rx_overflow || rx_stat.rate_dec_overflow || rx_stat.idle_cntr_inc))
        else $error("unused output not zero");
    chk_pkt_pulses: assert property (
        1'b1 |=> {rx_stat.sop_cntr_inc, rx_stat.eop_cntr_inc} == $past(pkt))
        else $error("packet pulse wrong");
    chk_reasm_ovf: assert property (
        rx_raw.rf_push && rf_diff[12] |=> rx_stat.reassembly_overrun_flag)
        else $error("reassembly overrun missing");
    chk_fill_level: assert property (1'b1 |=> rx_stat.fill_level == $past(fill))
        else $error("fill level wrong");

    cov_tx_ovf: cover property (tx_stat.overflow ##1 !tx_stat.overflow);
    cov_stretch: cover property (rx_stat.link_check_error [*4]);
    cov_reasm: cover property (rx_stat.reassembly_overrun_flag);
endmodule : lsm_monitor_asserts

bind lsm_link_status_monitor lsm_monitor_asserts u_chk (
    .mclk(mclk),
    .rst(rst),
    .tx_raw(tx_raw),
    .rx_raw(rx_raw),
    .tx_stat(tx_stat),
    .rx_stat(rx_stat)
);
`default_nettype wire

//--- tb/lsm_app_model.sv
// Purpose: application logic counting receive packet pulses
// Assumes: pulses are one mclk cycle wide
// Notes: counts wrap at 32 bits
`timescale 1ns/1ns
`default_nettype none
module lsm_app_model (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // status from the monitor
    input wire lsm_pkg::lsm_rx_stat_t rx_stat,
    // counts seen
    output logic [31:0] sop_seen,
    output logic [31:0] eop_seen
);
    // start of packet count
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            sop_seen <= 32'h0;
        end else if (rx_stat.sop_cntr_inc) begin
            sop_seen <= sop_seen + 32'h1;
        end
    end
    // end of packet count
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            eop_seen <= 32'h0;
        end else if (rx_stat.eop_cntr_inc) begin
            eop_seen <= eop_seen + 32'h1;
        end
    end
endmodule : lsm_app_model
`default_nettype wire

//--- tb/link_status_monitor_tb.sv
// Purpose: self-checking bench for the link status monitor
// Assumes: one-cycle status latency, registers over ahb-lite
// Notes: stimulus at rising edge, checks at falling edge
`timescale 1ns/1ns
`default_nettype none
module link_status_monitor_tb;
    logic mclk;
    logic rst = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    wire logic [31:0] hrdata;
    wire logic hreadyout;
    wire logic hresp;
    wire logic irq;
    lsm_pkg::lsm_tx_raw_t tx_raw = '0;
    lsm_pkg::lsm_rx_raw_t rx_raw = '0;
    wire lsm_pkg::lsm_tx_stat_t tx_stat;
    wire lsm_pkg::lsm_rx_stat_t rx_stat;
    wire logic [31:0] sop_seen;
    wire logic [31:0] eop_seen;
    int fails = 0;
    int compares = 0;
    int cycles = 0;

    lsm_link_status_monitor u_dut (.mclk(mclk), .rst(rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .tx_raw(tx_raw), .rx_raw(rx_raw), .tx_stat(tx_stat), .rx_stat(rx_stat), .irq(irq));
    lsm_app_model u_app (.mclk(mclk), .rst(rst), .rx_stat(rx_stat),
        .sop_seen(sop_seen), .eop_seen(eop_seen));

    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // one single transfer, entered just after a rising edge
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
            output logic [31:0] q);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= wr;
        htrans <= 2'h2;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask : bus

    task automatic print_verdict();
        $display("compares=%0d fails=%0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : print_verdict

    task automatic t_regs();
        logic [31:0] q;
        bus(1'b0, lsm_pkg::OFS_CTRL, 32'h0, q);
        chk(q, 32'h0);
        bus(1'b0, lsm_pkg::OFS_IRQ_MASK, 32'h0, q);
        chk(q, 32'h0);
        bus(1'b1, 8'h40, 32'hffff_ffff, q);
        bus(1'b0, 8'h40, 32'h0, q);
        chk(q, 32'h0);
        chk({31'h0, hresp}, 32'h0);
        chk({rx_stat.rx_overflow, rx_stat.rate_dec_overflow, rx_stat.idle_cntr_inc}, 32'h0);
    endtask : t_regs

    task automatic t_align();
        logic [3:0] pat;
        for (int i = 0; i < 5; i++) begin
            pat = 4'h1 << i;
            tx_raw.lane_aligned <= 4'hf ^ pat;
            rx_raw.lane_aligned <= 4'hf ^ pat;
            tx_raw.ready <= 1'b1;
            rx_raw.ready <= 1'b1;
            rx_raw.frame_lock <= pat;
            rx_raw.word_lock <= 4'hf ^ pat;
            @(posedge mclk);
            @(negedge mclk);
            chk(tx_stat.aligned, i == 4);
            chk(rx_stat.aligned, i == 4);
            chk(rx_stat.frame_locked, pat);
            chk(rx_stat.word_locked, 4'hf ^ pat);
            @(posedge mclk);
        end
        tx_raw.ready <= 1'b0;
        rx_raw.ready <= 1'b0;
        @(posedge mclk);
        @(negedge mclk);
        chk({tx_stat.aligned, rx_stat.aligned}, 32'h0);
        @(posedge mclk);
    endtask : t_align

    task automatic t_tx_flags();
        logic [31:0] q;
        tx_raw.wr_ptr <= 7'h40;
        tx_raw.push <= 1'b1;
        @(posedge mclk);
        tx_raw.push <= 1'b0;
        @(negedge mclk);
        chk(tx_stat.overflow, 1'b1);
        chk(irq, 1'b0);
        @(posedge mclk);
        bus(1'b1, lsm_pkg::OFS_IRQ_MASK, 32'h1, q);
        @(posedge mclk);
        @(negedge mclk);
        chk(irq, 1'b1);
        chk(tx_stat.overflow, 1'b1);
        @(posedge mclk);
        bus(1'b0, lsm_pkg::OFS_IRQ_STAT, 32'h0, q);
        chk(q[lsm_pkg::IRQ_TX_OVF], 1'b1);
        @(negedge mclk);
        chk(irq, 1'b0);
        @(posedge mclk);
        bus(1'b0, lsm_pkg::OFS_IRQ_STAT, 32'h0, q);
        chk(q[lsm_pkg::IRQ_TX_OVF], 1'b0);
        tx_raw.rd_ptr <= 7'h01;
        @(posedge mclk);
        @(negedge mclk);
        chk(tx_stat.overflow, 1'b0);
        @(posedge mclk);
        tx_raw.wr_ptr <= 7'h01;
        tx_raw.pop <= 1'b1;
        @(posedge mclk);
        tx_raw.pop <= 1'b0;
        @(negedge mclk);
        chk(tx_stat.underflow, 1'b1);
        @(posedge mclk);
    endtask : t_tx_flags

    task automatic crc_ev(input logic [1:0] src, input logic [3:0] lanes, input int len);
        logic [31:0] n;
        logic [31:0] m;
        n = 0;
        m = 0;
        rx_raw.ctl_check_fail <= src[1];
        rx_raw.data_check_fail <= src[0];
        rx_raw.lane_diag_fail <= lanes;
        @(posedge mclk);
        rx_raw.ctl_check_fail <= 1'b0;
        rx_raw.data_check_fail <= 1'b0;
        rx_raw.lane_diag_fail <= 4'h0;
        repeat (8) begin
            @(negedge mclk);
            n += rx_stat.link_check_error;
            m += (rx_stat.lane_diag_check_error === lanes);
        end
        chk(n, len);
        chk(m, len);
        @(posedge mclk);
    endtask : crc_ev

    task automatic t_checks();
        logic [31:0] q;
        bus(1'b1, lsm_pkg::OFS_CTRL, 32'h1, q);
        crc_ev(2'b10, 4'h1, 1);
        crc_ev(2'b01, 4'h2, 1);
        bus(1'b1, lsm_pkg::OFS_CTRL, 32'h0, q);
        crc_ev(2'b10, 4'h4, int'(lsm_pkg::CRC_STRETCH_CYC));
        crc_ev(2'b01, 4'h8, int'(lsm_pkg::CRC_STRETCH_CYC));
        bus(1'b0, lsm_pkg::OFS_CRC_CNT, 32'h0, q);
        chk(q, 32'h4);
    endtask : t_checks

    task automatic t_reasm();
        logic [31:0] q;
        rx_raw.rf_wr_ptr <= 13'h0064;
        @(posedge mclk);
        @(negedge mclk);
        chk(rx_stat.fill_level, 12'h064);
        chk($bits(rx_stat.fill_level), 32'hc);
        @(posedge mclk);
        bus(1'b0, lsm_pkg::OFS_FILL, 32'h0, q);
        chk(q, 32'h64);
        rx_raw.rf_wr_ptr <= 13'h1000;
        rx_raw.rf_push <= 1'b1;
        @(posedge mclk);
        rx_raw.rf_push <= 1'b0;
        @(negedge mclk);
        chk(rx_stat.reassembly_overrun_flag, 1'b1);
        @(posedge mclk);
        rx_raw.rf_rd_ptr <= 13'h0001;
        @(posedge mclk);
        @(negedge mclk);
        chk(rx_stat.reassembly_overrun_flag, 1'b0);
        chk(rx_stat.fill_level, 12'hfff);
        @(posedge mclk);
    endtask : t_reasm

    task automatic t_packets();
        logic [31:0] q;
        for (int i = 0; i < 3; i++) begin
            rx_raw.sop_out <= 1'b1;
            rx_raw.eop_out <= (i == 2);
            @(posedge mclk);
        end
        rx_raw.sop_out <= 1'b0;
        rx_raw.eop_out <= 1'b0;
        repeat (2) @(posedge mclk);
        @(negedge mclk);
        chk(sop_seen, 32'h3);
        chk(eop_seen, 32'h1);
        @(posedge mclk);
        bus(1'b0, lsm_pkg::OFS_SOP_CNT, 32'h0, q);
        chk(q, 32'h3);
        bus(1'b0, lsm_pkg::OFS_EOP_CNT, 32'h0, q);
        chk(q, 32'h1);
    endtask : t_packets

    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            fails++;
            print_verdict();
        end
    end

    initial begin
        repeat (10) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        t_regs();
        t_align();
        t_tx_flags();
        t_checks();
        t_reasm();
        t_packets();
        print_verdict();
    end
endmodule : link_status_monitor_tb
`default_nettype wire
